// *** common/pwm_waveform_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the waveform generator.
`ifndef PWM_WAVEFORM_REGS_VH
`define PWM_WAVEFORM_REGS_VH
`define OFF_IDENT        8'h00
`define OFF_CONTROL      8'h04
`define OFF_CONFIG       8'h08
`define OFF_START        8'h0c
`define OFF_REPEAT       8'h10
`define OFF_PERIOD       8'h14
`define OFF_PHASE1       8'h18
`define OFF_INT_STATUS   8'h1c
`define OFF_INT_MASK     8'h20
`define OFF_RUN_STATUS   8'h24
// Configuration field positions.
`define CFG_CONTINUOUS   0
`define CFG_HW_TRIG_EN   1
`define CFG_FALL_EDGE    2
`define CFG_VSYNC_EN     3
`define CFG_IDLE_LEVEL   4
`define CFG_FIRST_LEVEL  5
`define CFG_WIDTH        6
// Control field positions.
`define CTL_ENABLE       0
// Interrupt status field positions.
`define INT_PERIOD_END   0
`define INT_RUN_DONE     1
`define INT_WIDTH        2
// Reset values.
`define RST_CONFIG       6'h00
`define RST_PERIOD       32'h0000_0010
`define RST_PHASE1       32'h0000_0008
`define RST_REPEAT       8'h00
`define IDENT_VALUE      32'h0000_5a5a
// Length of the dma synchronisation pulse in clocks.
`define DMA_PULSE_CYCLES 1
`endif

// *** logic/edge_select.v ***
// Edge detector with selectable polarity for a trigger input.
`timescale 1ns/1ns
module edge_select (
	input  wire mclk,
	input  wire reset,
	input  wire trig_in,
	input  wire falling,
	output wire trig_pulse
);
	reg last;

	// Holds the previous level so that a transition can be seen.
	always @(posedge mclk) begin
		if (reset) begin
			last <= 1'b0;
		end else begin
			last <= trig_in;
		end
	end

	// Rising or falling transition chosen by the polarity input.
	assign trig_pulse = falling ? (last & ~trig_in) : (~last & trig_in);
endmodule

// *** logic/pwm_waveform_generator.v ***
// Pulse-width waveform generator with staged settings, one-shot and continuous runs.
//
// Summary of operation
// - Period and first-phase lengths are each held as a 32-bit count.
// - A counter runs over the period and a compare with the first-phase length splits it.
// - A one-shot run emits the 8-bit repeat count plus one periods and then stops.
// - Software selects one-shot operation or continuous operation that stops at the first period end after enable is cleared.
// - Period and first-phase settings are staged copies, not the live counters.
// - A hardware trigger edge, rising or falling by choice, can launch a one-shot run.
// - The image-sensor vertical sync can also launch a one-shot run.
// - While no waveform runs the output sits at a software-chosen idle level.
// - Period progress raises an interrupt request and a dma synchronisation pulse.
`timescale 1ns/1ns
`include "pwm_waveform_regs.vh"
module pwm_waveform_generator #(
	parameter CNT_WIDTH = 32,
	parameter RPT_WIDTH = 8
) (
	input  wire        mclk,
	input  wire        reset,
	input  wire [7:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire        hw_trigger,
	input  wire        image_sensor_vsync,
	output reg         waveform_output,
	output wire        irq,
	output reg         dma_sync
);
	localparam ST_IDLE = 2'b01;
	localparam ST_RUN  = 2'b10;

	reg [1:0]            state;
	reg [1:0]            next_state;
	reg                  enable;
	reg [`CFG_WIDTH-1:0] config_bits;
	reg [RPT_WIDTH-1:0]  repeat_stage;
	reg [CNT_WIDTH-1:0]  period_stage;
	reg [CNT_WIDTH-1:0]  phase1_stage;
	reg [CNT_WIDTH-1:0]  period_active;
	reg [CNT_WIDTH-1:0]  phase1_active;
	reg [CNT_WIDTH-1:0]  count;
	reg [RPT_WIDTH-1:0]  periods_left;
	reg [`INT_WIDTH-1:0] int_mask;
	wire [`INT_WIDTH-1:0] int_status;
	wire                 hw_edge;
	wire                 vsync_edge;
	wire                 sw_start;
	wire                 launch;
	wire                 period_end;
	wire                 last_period;
	wire                 run_done;
	wire                 continuous;
	wire [`INT_WIDTH-1:0] int_events;
	wire [`INT_WIDTH-1:0] int_clear;

	assign continuous = config_bits[`CFG_CONTINUOUS];

	// Edge detection for the external hardware trigger.
	edge_select u_hw_edge (
		.mclk       (mclk),
		.reset      (reset),
		.trig_in    (hw_trigger),
		.falling    (config_bits[`CFG_FALL_EDGE]),
		.trig_pulse (hw_edge)
	);

	// The vertical sync start is taken on its rising edge.
	edge_select u_vsync_edge (
		.mclk       (mclk),
		.reset      (reset),
		.trig_in    (image_sensor_vsync),
		.falling    (1'b0),
		.trig_pulse (vsync_edge)
	);

	// Start sources; only honoured while idle and the block is enabled.
	assign sw_start = wr && (addr == `OFF_START);
	assign launch = enable && (state == ST_IDLE) &&
		(sw_start || (config_bits[`CFG_HW_TRIG_EN] && hw_edge) ||
		(config_bits[`CFG_VSYNC_EN] && vsync_edge));

	// A period ends when the counter reaches the last count of the period.
	// A period length of zero behaves as one so that the run always ends.
	assign period_end = (state == ST_RUN) && ((period_active == {CNT_WIDTH{1'b0}}) ||
		(count >= period_active - {{(CNT_WIDTH-1){1'b0}}, 1'b1}));
	assign last_period = (periods_left == {RPT_WIDTH{1'b0}});
	assign run_done = period_end && ((!continuous && last_period) || !enable);

	// Run state: idle until launched, running until the last period ends.
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (launch) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (run_done) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always @(posedge mclk) begin
		if (reset) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Period counter, repeat countdown and loading of staged settings.
	always @(posedge mclk) begin
		if (reset) begin
			count <= {CNT_WIDTH{1'b0}};
			periods_left <= {RPT_WIDTH{1'b0}};
			period_active <= `RST_PERIOD;
			phase1_active <= `RST_PHASE1;
		end else if (launch) begin
			count <= {CNT_WIDTH{1'b0}};
			periods_left <= repeat_stage;
			period_active <= period_stage;
			phase1_active <= phase1_stage;
		end else if (period_end) begin
			count <= {CNT_WIDTH{1'b0}};
			period_active <= period_stage;
			phase1_active <= phase1_stage;
			if (!last_period) begin
				periods_left <= periods_left - {{(RPT_WIDTH-1){1'b0}}, 1'b1};
			end
		end else if (state == ST_RUN) begin
			count <= count + {{(CNT_WIDTH-1){1'b0}}, 1'b1};
		end
	end

	// Output: first level below the first-phase length, opposite after it, idle otherwise.
	always @(posedge mclk) begin
		if (reset) begin
			waveform_output <= 1'b0;
		end else if (next_state == ST_RUN) begin
			if ((launch || period_end) ? (phase1_stage != {CNT_WIDTH{1'b0}}) :
				(count + {{(CNT_WIDTH-1){1'b0}}, 1'b1} < phase1_active)) begin
				waveform_output <= config_bits[`CFG_FIRST_LEVEL];
			end else begin
				waveform_output <= ~config_bits[`CFG_FIRST_LEVEL];
			end
		end else begin
			waveform_output <= config_bits[`CFG_IDLE_LEVEL];
		end
	end

	// Dma synchronisation pulse at every period end.
	always @(posedge mclk) begin
		if (reset) begin
			dma_sync <= 1'b0;
		end else begin
			dma_sync <= period_end;
		end
	end

	// Software-visible registers and their writes.
	always @(posedge mclk) begin
		if (reset) begin
			enable <= 1'b0;
			config_bits <= `RST_CONFIG;
			repeat_stage <= `RST_REPEAT;
			period_stage <= `RST_PERIOD;
			phase1_stage <= `RST_PHASE1;
			int_mask <= {`INT_WIDTH{1'b0}};
		end else if (wr) begin
			if (addr == `OFF_CONTROL) begin
				enable <= wdata[`CTL_ENABLE];
			end else if (addr == `OFF_CONFIG) begin
				config_bits <= wdata[`CFG_WIDTH-1:0];
			end else if (addr == `OFF_REPEAT) begin
				repeat_stage <= wdata[RPT_WIDTH-1:0];
			end else if (addr == `OFF_PERIOD) begin
				period_stage <= wdata[CNT_WIDTH-1:0];
			end else if (addr == `OFF_PHASE1) begin
				phase1_stage <= wdata[CNT_WIDTH-1:0];
			end else if (addr == `OFF_INT_MASK) begin
				int_mask <= wdata[`INT_WIDTH-1:0];
			end
		end
	end

	// Interrupt events: period end and run completion.
	assign int_events = {run_done, period_end};
	assign int_clear = (wr && (addr == `OFF_INT_STATUS)) ? wdata[`INT_WIDTH-1:0] :
		{`INT_WIDTH{1'b0}};

	sticky_irq #(
		.WIDTH (`INT_WIDTH)
	) u_irq (
		.mclk       (mclk),
		.reset      (reset),
		.event_set  (int_events),
		.clear_bits (int_clear),
		.mask       (int_mask),
		.status     (int_status),
		.irq        (irq)
	);

	// Read data, valid in the cycle after the read strobe; unmapped reads give zero.
	always @(posedge mclk) begin
		if (reset) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			if (addr == `OFF_IDENT) begin
				rdata <= `IDENT_VALUE;
			end else if (addr == `OFF_CONTROL) begin
				rdata <= {31'h0000_0000, enable};
			end else if (addr == `OFF_CONFIG) begin
				rdata <= {26'h000_0000, config_bits};
			end else if (addr == `OFF_REPEAT) begin
				rdata <= {24'h00_0000, repeat_stage};
			end else if (addr == `OFF_PERIOD) begin
				rdata <= period_stage;
			end else if (addr == `OFF_PHASE1) begin
				rdata <= phase1_stage;
			end else if (addr == `OFF_INT_STATUS) begin
				rdata <= {30'h0000_0000, int_status};
			end else if (addr == `OFF_INT_MASK) begin
				rdata <= {30'h0000_0000, int_mask};
			end else if (addr == `OFF_RUN_STATUS) begin
				rdata <= {23'h00_0000, periods_left, state == ST_RUN};
			end else begin
				rdata <= 32'h0000_0000;
			end
		end else begin
			rdata <= 32'h0000_0000;
		end
	end
endmodule

// *** logic/sticky_irq.v ***
// Sticky interrupt status bits with write-one-to-clear and a mask.
`timescale 1ns/1ns
module sticky_irq #(
	parameter WIDTH = 2
) (
	input  wire             mclk,
	input  wire             reset,
	input  wire [WIDTH-1:0] event_set,
	input  wire [WIDTH-1:0] clear_bits,
	input  wire [WIDTH-1:0] mask,
	output reg  [WIDTH-1:0] status,
	output wire             irq
);
	genvar i;

	// Each bit sets on its event; a set in the clear cycle wins.
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			always @(posedge mclk) begin
				if (reset) begin
					status[i] <= 1'b0;
				end else if (event_set[i]) begin
					status[i] <= 1'b1;
				end else if (clear_bits[i]) begin
					status[i] <= 1'b0;
				end
			end
		end
	endgenerate

	// Level interrupt while any unmasked bit is set.
	assign irq = |(status & mask);
endmodule

// *** test/pwm_load.sv ***
// Load model that counts high cycles and rising edges seen on the waveform pin.
`timescale 1ns/1ns
module pwm_load (
	input  wire         mclk,
	input  wire         clr,
	input  wire         waveform_output,
	output logic [15:0] high_count,
	output logic [15:0] rise_count
);
	logic prev;
	// The bench clears the counts before each measured run.
	always @(posedge mclk) begin
		prev <= waveform_output;
		if (clr) begin
			high_count <= 16'h0000;
			rise_count <= 16'h0000;
		end else begin
			high_count <= high_count + {15'h0000, waveform_output};
			rise_count <= rise_count + {15'h0000, waveform_output & ~prev};
		end
	end
endmodule

// *** test/pwm_waveform_asserts.sv ***
// Concurrent checks on the ports of the waveform generator.
`timescale 1ns/1ns
`include "pwm_waveform_regs.vh"
module pwm_waveform_checker (
	input wire        mclk,
	input wire        reset,
	input wire [7:0]  addr,
	input wire [31:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [31:0] rdata,
	input wire        waveform_output,
	input wire        irq,
	input wire        dma_sync
);
	logic [31:0] period_seen;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Shadow of the staged period as software wrote it.
	always @(posedge mclk) begin
		if (reset)
			period_seen <= `RST_PERIOD;
		else if (wr && addr == `OFF_PERIOD)
			period_seen <= wdata;
	end
	AST_RESET_QUIET: assert property ($past(reset) |-> !waveform_output && !dma_sync && !irq)
		else $error("outputs not idle after reset");
	AST_RDATA_ZERO: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	AST_IDENT: assert property ($past(rd) && $past(addr) == `OFF_IDENT |-> rdata == `IDENT_VALUE)
		else $error("identification value wrong");
	AST_PERIOD_READBACK: assert property ($past(rd) && $past(addr) == `OFF_PERIOD |-> rdata == period_seen)
		else $error("period setting lost");
	AST_START_READ: assert property ($past(rd) && $past(addr) == `OFF_START |-> rdata == 32'h0000_0000)
		else $error("start register read nonzero");
	AST_UNMAPPED: assert property ($past(rd) && $past(addr) > 8'h24 |-> rdata == 32'h0000_0000)
		else $error("unmapped read nonzero");
	AST_IRQ_CAUSE: assert property ($rose(irq) |-> dma_sync || $past(dma_sync) || $past(wr))
		else $error("interrupt without cause");
	AST_IRQ_MASKED: assert property (wr && addr == `OFF_INT_MASK && wdata[1:0] == 2'b00 |=> !irq)
		else $error("masked interrupt still high");
	cover property (dma_sync);
	cover property ($rose(irq));
	cover property ($rose(waveform_output));
endmodule
bind pwm_waveform_generator pwm_waveform_checker chk (.mclk(mclk), .reset(reset), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .waveform_output(waveform_output),
	.irq(irq), .dma_sync(dma_sync));

// *** test/pwm_waveform_generator_test.sv ***
// Register-level bench for the waveform generator with a counting load.
`timescale 1ns/1ns
`include "pwm_waveform_regs.vh"
module pwm_waveform_generator_test;
	logic        mclk = 0, reset = 1, wr = 0, rd = 0, hw_trigger = 0, vsync = 0, clr = 1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rv;
	wire  [31:0] rdata;
	wire         waveform_output, irq, dma_sync;
	wire  [15:0] high_count, rise_count;
	int          errors = 0, checked = 0, cycles = 0, dmas = 0, base, e;
	pwm_waveform_generator dut (.mclk(mclk), .reset(reset), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .hw_trigger(hw_trigger),
		.image_sensor_vsync(vsync), .waveform_output(waveform_output), .irq(irq),
		.dma_sync(dma_sync));
	pwm_load load (.mclk(mclk), .clr(clr), .waveform_output(waveform_output),
		.high_count(high_count), .rise_count(rise_count));
	// Clock at 25 MHz.
	initial begin
		forever #20 mclk = ~mclk;
	end
	// Cycle ceiling and dma pulse tally.
	always @(posedge mclk) begin
		cycles++;
		if (dma_sync === 1'b1)
			dmas++;
		if (cycles == 3000) begin
			errors++;
			end_of_test;
		end
	end
	task end_of_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 rv = rdata;
	endtask
	task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		rd_reg(a);
		chk(name, exp, rv);
	endtask
	// One-shot run by start write, a second start mid-run must be ignored.
	task shot(input int rep, input int per, input int ph);
		wr_reg(`OFF_REPEAT, rep);
		wr_reg(`OFF_PERIOD, per);
		wr_reg(`OFF_PHASE1, ph);
		clr <= 1'b1;
		base = dmas;
		wr_reg(`OFF_START, 32'h0000_0001);
		clr <= 1'b0;
		// A second start only lands mid-run when the run outlasts the write.
		if ((rep + 1) * per > 2)
			wr_reg(`OFF_START, 32'h0000_0001);
		repeat ((rep + 1) * per + 6) @(posedge mclk);
		chk("high cycles", (rep + 1) * ph, high_count);
		chk("periods", (ph < per) ? rep + 1 : 1, rise_count);
		chk("dma pulses", rep + 1, dmas - base);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		reset <= 1'b0;
		clr <= 1'b0;
		wr_reg(`OFF_IDENT, 32'h0000_1234);
		rd_chk("ident", `OFF_IDENT, `IDENT_VALUE);
		rd_chk("config", `OFF_CONFIG, 32'h0000_0000);
		rd_chk("period", `OFF_PERIOD, 32'h0000_0010);
		rd_chk("phase", `OFF_PHASE1, 32'h0000_0008);
		rd_chk("repeat", `OFF_REPEAT, 32'h0000_0000);
		rd_chk("unmapped", 8'h40, 32'h0000_0000);
		wr_reg(`OFF_CONFIG, 32'h0000_0020);
		wr_reg(`OFF_START, 32'h0000_0001);
		repeat (20) @(posedge mclk);
		chk("disabled run", 0, rise_count);
		wr_reg(`OFF_CONTROL, 32'h0000_0001);
		shot(2, 4, 2);
		rd_chk("status", `OFF_INT_STATUS, 32'h0000_0003);
		chk("irq masked", 1'b0, irq);
		wr_reg(`OFF_INT_MASK, 32'h0000_0002);
		#1 chk("irq on", 1'b1, irq);
		wr_reg(`OFF_INT_STATUS, 32'h0000_0003);
		#1 chk("irq cleared", 1'b0, irq);
		shot(0, 1, 1);
		shot(0, 8, 4);
		wr_reg(`OFF_CONFIG, 32'h0000_0010);
		repeat (3) @(posedge mclk);
		chk("idle level", 1'b1, waveform_output);
		for (e = 0; e < 2; e++) begin
			wr_reg(`OFF_CONFIG, e ? 32'h0000_0026 : 32'h0000_0022);
			// Let the pin settle to the new low idle level before the trigger.
			repeat (2) @(posedge mclk);
			clr <= 1'b1;
			hw_trigger <= 1'b1;
			@(posedge mclk);
			clr <= 1'b0;
			repeat (14) @(posedge mclk);
			chk("first edge", e ? 0 : 1, rise_count);
			hw_trigger <= 1'b0;
			repeat (14) @(posedge mclk);
			chk("second edge", 1, rise_count);
		end
		wr_reg(`OFF_CONFIG, 32'h0000_0028);
		clr <= 1'b1;
		vsync <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		repeat (14) @(posedge mclk);
		chk("vsync run", 1, rise_count);
		vsync <= 1'b0;
		wr_reg(`OFF_CONFIG, 32'h0000_0021);
		wr_reg(`OFF_START, 32'h0000_0001);
		repeat (30) @(posedge mclk);
		rd_reg(`OFF_RUN_STATUS);
		chk("continuous", 1'b1, rv[0]);
		wr_reg(`OFF_CONTROL, 32'h0000_0000);
		repeat (12) @(posedge mclk);
		rd_reg(`OFF_RUN_STATUS);
		chk("stopped", 1'b0, rv[0]);
		end_of_test;
	end
endmodule
